/* File: design/bit_time_counter.sv */
// Counts a programmed number of bit times for the turnaround delay.
`timescale 1ns/100ps
`default_nettype none
module bit_time_counter (
    // Clock and reset.
    input  wire logic       pclk,
    input  wire logic       presetn,
    // Control.
    input  wire logic       start,
    input  wire logic [3:0] bit_count,
    input  wire logic       bit_tick,
    // Result.
    output logic            done
);
    logic [3:0] left_q;
    logic       busy_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left_q <= 4'h0;
            busy_q <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start) begin
                if (bit_count == 4'h0) begin
                    done <= 1'b1;
                end else begin
                    left_q <= bit_count;
                    busy_q <= 1'b1;
                end
            end else if (busy_q && bit_tick) begin
                if (left_q == 4'h1) begin
                    busy_q <= 1'b0;
                    done   <= 1'b1;
                end
                left_q <= left_q - 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

/* File: design/uart_modem_status_rs485_ctrl.sv */
// Modem status deltas, RS-485 direction, disables, scratch and features.
`timescale 1ns/100ps
`default_nettype none
`include "uart_msr_defines.svh"

// Summary of operation
// - Carrier-detect delta flags any level change.
// - Ring delta sets only on rising input.
// - DSR and CTS deltas flag either edge.
// - Any delta with enable raises interrupt.
// - Wait programmed bit times before dropping direction.
// - Delay code is plain binary bit count.
// - Delay writes need enhanced-function enable.
// - Transmit disable halts shifter, holds data.
// - Receive disable finishes current char, then stops.
// - Re-enable receiver at once, even mid-character.
// - Receive FIFO stays readable when disabled.
// - Tx disable mode gates flow-control characters.
// - Rx disable mode keeps or drops flow detection.
// - Scratch byte read/write, resets to ones.
// - Trigger table select, one-level hysteresis.
// - RS-485 control overrides auto flow control.
// - Direction rises on load, before start bit.
// - Direction falls after last stop plus delay.
// - Tx interrupt source follows RS-485 mode.
// - Flow chars with empty FIFO do not raise direction.
// - Infrared receive polarity select.
module uart_modem_status_rs485_ctrl (
    // APB slave.
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Modem input pins, active low, and the infrared receive input.
    input  wire logic        carrier_detect_in_n,
    input  wire logic        ring_indicator_in_n,
    input  wire logic        data_set_ready_in_n,
    input  wire logic        clear_to_send_in_n,
    input  wire logic        ir_rx_in,
    // Datapath status from the channel core.
    input  wire logic        tx_fifo_load,
    input  wire logic        tx_fifo_empty,
    input  wire logic        tx_shift_empty,
    input  wire logic        tx_flow_char_pending,
    input  wire logic        rx_char_busy,
    input  wire logic        rx_fifo_rts_request,
    input  wire logic        bit_tick,
    // Datapath controls to the channel core.
    output logic             tx_shift_enable,
    output logic             tx_flow_char_enable,
    output logic             rx_data_accept,
    output logic             rx_flow_detect,
    output logic             rx_fifo_read_allow,
    output logic [1:0]       trigger_table,
    output logic             ir_rx_decoded,
    // Serial side outputs.
    output logic             direction_out,
    output logic             modem_irq,
    output logic             tx_irq
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    // Only the second and third stages feed logic; the first may be metastable.
    logic [4:0] pins_meta_q;
    logic [4:0] pins_q;
    logic [4:0] pins_prev_q;
    logic [4:0] pins_raw;

    assign pins_raw = {ir_rx_in, carrier_detect_in_n, ring_indicator_in_n,
                       data_set_ready_in_n, clear_to_send_in_n};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_meta_q <= 5'h0f;
            pins_q      <= 5'h0f;
            pins_prev_q <= 5'h0f;
        end else begin
            pins_meta_q <= pins_raw;
            pins_q      <= pins_meta_q;
            pins_prev_q <= pins_q;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] ier_q;
    logic [7:0] efr_q;
    logic [7:0] scratch_q;
    logic [7:0] feature_control_q;
    logic [3:0] turn_delay_q;
    logic [3:0] disable_q;
    logic [3:0] delta_q;
    logic       wr_en;
    logic       rd_en;
    logic       addr_ok;
    logic       status_read;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign addr_ok = (paddr == `OFS_INTERRUPT_ENABLE) ||
                     (paddr == `OFS_ENHANCED_FEATURE) ||
                     (paddr == `OFS_MODEM_STATUS) ||
                     (paddr == `OFS_SCRATCH) ||
                     (paddr == `OFS_FEATURE_CONTROL) ||
                     (paddr == `OFS_DATAPATH_STATUS);
    assign status_read = rd_en && (paddr == `OFS_MODEM_STATUS);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ier_q     <= 8'h00;
            efr_q     <= 8'h00;
            scratch_q <= `SCRATCH_RESET;
            feature_control_q    <= 8'h00;
        end else if (wr_en) begin
            case (paddr)
                `OFS_INTERRUPT_ENABLE: ier_q <= pwdata[7:0];
                `OFS_ENHANCED_FEATURE: efr_q <= pwdata[7:0];
                `OFS_SCRATCH:          scratch_q <= pwdata[7:0];
                `OFS_FEATURE_CONTROL:  feature_control_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // The whole write-only view is locked unless enhanced writes are on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            turn_delay_q <= 4'h0;
            disable_q    <= 4'h0;
        end else if (wr_en && paddr == `OFS_MODEM_STATUS
                     && efr_q[`EFR_ENHANCED_BIT]) begin
            turn_delay_q <= pwdata[7:4];
            disable_q    <= pwdata[3:0];
        end
    end

    // ------------------------------------------------------------
    // Delta flags
    // ------------------------------------------------------------
    logic [3:0] delta_set;

    // Index 2 is ring: the inverted status bit falls when the pin rises.
    assign delta_set[3] = pins_q[3] ^ pins_prev_q[3];
    assign delta_set[2] = pins_q[2] & ~pins_prev_q[2];
    assign delta_set[1] = pins_q[1] ^ pins_prev_q[1];
    assign delta_set[0] = pins_q[0] ^ pins_prev_q[0];

    // A change landing in the read cycle survives the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delta_q <= 4'h0;
        end else begin
            delta_q <= (status_read ? 4'h0 : delta_q) | delta_set;
        end
    end

    // ------------------------------------------------------------
    // APB read path
    // ------------------------------------------------------------
    logic [7:0] rd_byte;

    // A change seen in the setup cycle is reported, not lost to the clear.
    always_comb begin
        case (paddr)
            `OFS_INTERRUPT_ENABLE: rd_byte = ier_q;
            `OFS_ENHANCED_FEATURE: rd_byte = efr_q;
            `OFS_MODEM_STATUS:     rd_byte = {~pins_q[3:0],
                                             delta_q | delta_set};
            `OFS_SCRATCH:          rd_byte = scratch_q;
            `OFS_FEATURE_CONTROL:  rd_byte = feature_control_q;
            `OFS_DATAPATH_STATUS:  rd_byte = {turn_delay_q, disable_q};
            default:               rd_byte = 8'h00;
        endcase
    end

    // Zero wait states keep the slave simple; every access ends at once.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !(addr_ok ||
                       paddr == `OFS_MODEM_STATUS);
            // A write answers zero so an error never shows stale data.
            if (psel && !penable) begin
                prdata <= pwrite ? 32'h0000_0000 : {24'h000000, rd_byte};
            end
        end
    end

    // ------------------------------------------------------------
    // Transmit and receive disables
    // ------------------------------------------------------------
    logic rx_disable;
    logic rx_halted_q;

    assign rx_disable = disable_q[`TDC_RX_DISABLE_BIT];

    // The character in progress still completes before the halt bites.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_halted_q <= 1'b0;
        end else if (!rx_disable) begin
            rx_halted_q <= 1'b0;
        end else if (!rx_char_busy) begin
            rx_halted_q <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shift_enable     <= 1'b1;
            tx_flow_char_enable <= 1'b1;
            rx_data_accept      <= 1'b1;
            rx_flow_detect      <= 1'b1;
            rx_fifo_read_allow  <= 1'b1;
        end else begin
            tx_shift_enable <= !disable_q[`TDC_TX_DISABLE_BIT];
            tx_flow_char_enable <= !disable_q[`TDC_TX_DISABLE_BIT]
                || disable_q[`TDC_TX_MODE_BIT]
                || tx_flow_char_pending;
            rx_data_accept <= !rx_halted_q;
            rx_flow_detect <= !rx_halted_q
                || disable_q[`TDC_RX_MODE_BIT];
            rx_fifo_read_allow <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Features, infrared polarity and auto flow control
    // ------------------------------------------------------------
    logic rs485_on;
    logic rts_flow_q;

    assign rs485_on = feature_control_q[`FEATURE_CONTROL_RS485_BIT];

    // The core raises its request one level above and drops it one below.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trigger_table <= 2'b00;
            ir_rx_decoded <= 1'b0;
            rts_flow_q    <= 1'b0;
        end else begin
            trigger_table <= feature_control_q[7:6];
            ir_rx_decoded <= pins_q[4] ^ feature_control_q[`FEATURE_CONTROL_IR_POL_BIT];
            rts_flow_q    <= rx_fifo_rts_request;
        end
    end

    // ------------------------------------------------------------
    // RS-485 direction control
    // ------------------------------------------------------------
    uart_msr_pkg::dir_state_t dir_state_q;
    logic delay_start;
    logic delay_done;
    logic tx_idle;

    // A flow character with an empty FIFO never counts as a load.
    assign tx_idle = tx_fifo_empty && tx_shift_empty;
    assign delay_start = (dir_state_q == uart_msr_pkg::DIR_SEND) && tx_idle
                         && !tx_fifo_load;

    bit_time_counter u_turn_delay (
        .pclk      (pclk),
        .presetn   (presetn),
        .start     (delay_start),
        .bit_count (turn_delay_q),
        .bit_tick  (bit_tick),
        .done      (delay_done)
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_state_q <= uart_msr_pkg::DIR_IDLE;
        end else if (!rs485_on) begin
            dir_state_q <= uart_msr_pkg::DIR_IDLE;
        end else begin
            case (dir_state_q)
                uart_msr_pkg::DIR_IDLE: begin
                    if (tx_fifo_load) begin
                        dir_state_q <= uart_msr_pkg::DIR_SEND;
                    end
                end
                uart_msr_pkg::DIR_SEND: begin
                    if (delay_start) begin
                        dir_state_q <= uart_msr_pkg::DIR_HOLD;
                    end
                end
                uart_msr_pkg::DIR_HOLD: begin
                    if (tx_fifo_load) begin
                        dir_state_q <= uart_msr_pkg::DIR_SEND;
                    end else if (delay_done) begin
                        dir_state_q <= uart_msr_pkg::DIR_IDLE;
                    end
                end
                default: dir_state_q <= uart_msr_pkg::DIR_IDLE;
            endcase
        end
    end

    // The load is seen combinationally so the pin leads the start bit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            direction_out <= 1'b0;
        end else if (rs485_on) begin
            direction_out <= tx_fifo_load ||
                (dir_state_q != uart_msr_pkg::DIR_IDLE
                 && !(dir_state_q == uart_msr_pkg::DIR_HOLD
                      && delay_done));
        end else begin
            direction_out <= rts_flow_q;
        end
    end

    // ------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------
    // The modem interrupt holds until a status read clears the deltas.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_irq <= 1'b0;
            tx_irq    <= 1'b0;
        end else begin
            modem_irq <= (|delta_q) && ier_q[`IER_MODEM_BIT];
            tx_irq <= rs485_on ? tx_idle : tx_fifo_empty;
        end
    end
endmodule
`default_nettype wire

/* File: design/uart_msr_defines.svh */
// Register offsets, field positions, reset values and timing counts.
`ifndef UART_MSR_DEFINES_SVH
`define UART_MSR_DEFINES_SVH
`define OFS_INTERRUPT_ENABLE   8'h00
`define OFS_ENHANCED_FEATURE   8'h04
`define OFS_MODEM_STATUS       8'h08
`define OFS_SCRATCH            8'h0c
`define OFS_FEATURE_CONTROL    8'h10
`define OFS_DATAPATH_STATUS    8'h14
`define IER_MODEM_BIT          3
`define EFR_ENHANCED_BIT       4
`define FEATURE_CONTROL_RS485_BIT         5
`define FEATURE_CONTROL_IR_POL_BIT        4
`define TDC_TX_DISABLE_BIT     3
`define TDC_RX_DISABLE_BIT     2
`define TDC_TX_MODE_BIT        1
`define TDC_RX_MODE_BIT        0
`define SCRATCH_RESET          8'hff
`define BAUD_DIV_RESET         16'h000a
`endif

/* File: design/uart_msr_pkg.sv */
// Types shared by the modem status and RS-485 control block.
package uart_msr_pkg;
    typedef enum logic [1:0] {
        TRIG_TABLE_A,
        TRIG_TABLE_B,
        TRIG_TABLE_C,
        TRIG_TABLE_D
    } trig_table_t;
    typedef enum {
        DIR_IDLE,
        DIR_SEND,
        DIR_HOLD
    } dir_state_t;
endpackage

/* File: tb/tb_uart_modem_status_rs485_ctrl.sv */
// Self-checking bench for the modem status and RS-485 control block.
`timescale 1ns/100ps
`default_nettype none
`include "uart_msr_defines.svh"
module tb_uart_modem_status_rs485_ctrl;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [7:0]  paddr, v;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pins_n, old, nxt;
    logic        ir_rx_in, tx_fifo_load, tx_fifo_empty, tx_shift_empty;
    logic        tx_flow_char_pending, rx_char_busy, bit_tick;
    logic        tx_shift_enable, tx_flow_char_enable, rx_data_accept;
    logic        rx_flow_detect, rx_fifo_read_allow, ir_rx_decoded;
    logic        direction_out, modem_irq, tx_irq, rts_req;
    logic [1:0]  trigger_table;
    int          err_total, n_checks, seed, k, cnt;
    // ----
    // Design and far side
    // ----
    uart_modem_status_rs485_ctrl uut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .carrier_detect_in_n(pins_n[3]), .ring_indicator_in_n(pins_n[2]),
        .data_set_ready_in_n(pins_n[1]), .clear_to_send_in_n(pins_n[0]),
        .ir_rx_in, .tx_fifo_load, .tx_fifo_empty, .tx_shift_empty,
        .tx_flow_char_pending, .rx_char_busy, .rx_fifo_rts_request(rts_req),
        .bit_tick, .tx_shift_enable, .tx_flow_char_enable, .rx_data_accept,
        .rx_flow_detect, .rx_fifo_read_allow, .trigger_table, .ir_rx_decoded,
        .direction_out, .modem_irq, .tx_irq);
    tx_core_model model (.pclk, .presetn, .tx_fifo_load, .tx_shift_enable,
        .tx_fifo_empty, .tx_shift_empty, .bit_tick);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (err_total == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic tmo(input int n);
        if (n >= 400) begin
            err_total++;
            final_report();
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        tmo(n * 20);
    endtask
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    // ----
    // Main sequence
    // ----
    initial begin
        seed = 47357;
        {presetn, psel, penable, pwrite, paddr, pwdata, rts_req} = '0;
        {ir_rx_in, tx_fifo_load, tx_flow_char_pending, rx_char_busy} = '0;
        pins_n = 4'hf;
        cyc(4);
        presetn <= 1'b1;
        cyc(4);
        apb(0, `OFS_SCRATCH, 8'h00);
        chk(rd, 32'hff);
        for (int i = 0; i < 3; i++) begin
            v = 8'($random(seed));
            apb(1, `OFS_SCRATCH, v);
            apb(0, `OFS_SCRATCH, 8'h00);
            chk(rd, {24'h0, v});
        end
        apb(0, 8'h18, 8'h00);
        chk({31'h0, er}, 32'h1);
        chk(rd, 32'h0);
        old = 4'hf;
        for (int i = 0; i < 8; i++) begin
            apb(1, `OFS_INTERRUPT_ENABLE, (i < 6) ? 8'h08 : 8'h00);
            nxt = (i == 0) ? 4'h0 : (i == 1) ? 4'hf : 4'($random(seed));
            pins_n <= nxt;
            cyc(6);
            v[3:0] = old ^ nxt;
            v[2] = ~old[2] & nxt[2];
            chk(modem_irq, (i < 6) && v[3:0] != 4'h0);
            apb(0, `OFS_MODEM_STATUS, 8'h00);
            chk(rd, {24'h0, ~nxt, v[3:0]});
            apb(0, `OFS_MODEM_STATUS, 8'h00);
            chk(rd, {24'h0, ~nxt, 4'h0});
            chk(modem_irq, 1'b0);
            old = nxt;
        end
        apb(1, `OFS_MODEM_STATUS, 8'h5f);
        apb(0, `OFS_DATAPATH_STATUS, 8'h00);
        chk(rd, 32'h0);
        apb(1, `OFS_ENHANCED_FEATURE, 8'h10);
        rx_char_busy <= 1'b1;
        apb(1, `OFS_MODEM_STATUS, 8'h0f);
        apb(0, `OFS_DATAPATH_STATUS, 8'h00);
        chk(rd, 32'h0f);
        chk({rx_data_accept, tx_shift_enable}, 2'b10);
        chk({tx_flow_char_enable, rx_flow_detect}, 2'b11);
        rx_char_busy <= 1'b0;
        cyc(3);
        chk(rx_data_accept, 1'b0);
        apb(1, `OFS_MODEM_STATUS, 8'h0c);
        cyc(2);
        chk({tx_flow_char_enable, rx_flow_detect}, 2'b00);
        tx_flow_char_pending <= 1'b1;
        tx_fifo_load <= 1'b1;
        @(posedge pclk) tx_fifo_load <= 1'b0;
        cyc(40);
        chk({tx_flow_char_enable, tx_fifo_empty}, 2'b10);
        chk(tx_irq, 1'b0);
        tx_flow_char_pending <= 1'b0;
        apb(1, `OFS_MODEM_STATUS, 8'h00);
        for (k = 0; k < 400 && !(tx_fifo_empty && tx_shift_empty); k++) cyc(1);
        tmo(k);
        cyc(2);
        chk(tx_irq, 1'b1);
        chk({rx_data_accept, tx_shift_enable}, 2'b11);
        for (int t = 0; t < 4; t++) begin
            v = {t[1:0], 1'b0, t[0], 4'h0};
            ir_rx_in <= 1'($random(seed));
            apb(1, `OFS_FEATURE_CONTROL, v);
            cyc(4);
            chk(trigger_table, t[1:0]);
            chk(ir_rx_decoded, ir_rx_in ^ t[0]);
            apb(0, `OFS_FEATURE_CONTROL, 8'h00);
            chk(rd, {24'h0, v});
        end
        apb(1, `OFS_FEATURE_CONTROL, 8'h20);
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 8'h00 : (i == 1) ? 8'h10 : (i == 2) ? 8'hf0 :
                {4'($random(seed)), 4'h0};
            apb(1, `OFS_MODEM_STATUS, v);
            tx_fifo_load <= 1'b1;
            @(posedge pclk) tx_fifo_load <= 1'b0;
            @(posedge pclk);
            chk(direction_out, 1'b1);
            cyc(12);
            chk({tx_irq, tx_shift_empty}, 2'b00);
            for (k = 0; k < 400 && !(tx_fifo_empty && tx_shift_empty); k++)
                cyc(1);
            tmo(k);
            cnt = 0;
            for (k = 0; k < 400 && direction_out; k++) begin
                @(posedge pclk);
                cnt += int'(bit_tick);
            end
            tmo(k);
            chk(cnt >= v[7:4] && cnt <= v[7:4] + 1, 1'b1);
            tx_flow_char_pending <= 1'b1;
            rts_req <= 1'b1;
            cyc(20);
            chk({direction_out, tx_irq}, 2'b01);
            tx_flow_char_pending <= 1'b0;
            rts_req <= 1'b0;
        end
        presetn <= 1'b0;
        cyc(2);
        presetn <= 1'b1;
        cyc(4);
        apb(0, `OFS_SCRATCH, 8'h00);
        chk(rd, 32'hff);
        final_report();
    end
endmodule
`default_nettype wire

/* File: tb/tx_core_model.sv */
// Transmit FIFO and shifter model standing in for the channel core.
`timescale 1ns/100ps
`default_nettype none
module tx_core_model #(
    parameter int TICK_DIV = 4
) (
    // Clock and reset.
    input  wire logic pclk,
    input  wire logic presetn,
    // Load from the bench, shift enable from the block.
    input  wire logic tx_fifo_load,
    input  wire logic tx_shift_enable,
    // To the block.
    output logic      tx_fifo_empty,
    output logic      tx_shift_empty,
    output logic      bit_tick
);
    int fifo_q;
    int bits_q;
    int div_q;
    // A character is ten bit times; it only starts on a bit tick.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_q <= 0;
            bits_q <= 0;
            div_q <= 0;
            bit_tick <= 1'b0;
        end else begin
            div_q <= (div_q == TICK_DIV - 1) ? 0 : div_q + 1;
            bit_tick <= (div_q == TICK_DIV - 1);
            if (bits_q == 0 && fifo_q != 0 && tx_shift_enable
                && bit_tick) begin
                fifo_q <= fifo_q - 1 + int'(tx_fifo_load);
                bits_q <= 10;
            end else begin
                fifo_q <= fifo_q + int'(tx_fifo_load);
                if (bits_q != 0 && bit_tick) bits_q <= bits_q - 1;
            end
        end
    end
    assign tx_fifo_empty = (fifo_q == 0);
    assign tx_shift_empty = (bits_q == 0);
endmodule
`default_nettype wire

/* File: tb/uart_msr_sva.sv */
// Port checker for the modem status and RS-485 control block.
`timescale 1ns/100ps
`default_nettype none
module uart_msr_sva (
    // Bus.
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Datapath.
    input wire logic        tx_fifo_load,
    input wire logic        tx_fifo_empty,
    input wire logic        tx_shift_empty,
    input wire logic        rx_char_busy,
    input wire logic        rx_data_accept,
    input wire logic        rx_fifo_read_allow,
    input wire logic        direction_out
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_access: assert property (psel && !penable |=> pready)
        else $error("no ready in access cycle");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response with data");
    a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_dir_rise_load: assert property (
        $rose(direction_out) |-> $past(tx_fifo_load))
        else $error("direction rose without a load");
    a_dir_fall_idle: assert property (
        $fell(direction_out) |-> $past(tx_fifo_empty && tx_shift_empty))
        else $error("direction fell while sending");
    a_rx_halt_char: assert property (
        $fell(rx_data_accept) |-> !$past(rx_char_busy, 2))
        else $error("receiver halted mid character");
    a_fifo_readable: assert property (rx_fifo_read_allow)
        else $error("receive FIFO read blocked");
endmodule
bind uart_modem_status_rs485_ctrl uart_msr_sva chk (.pclk, .presetn, .psel,
    .penable, .prdata, .pready, .pslverr, .tx_fifo_load, .tx_fifo_empty,
    .tx_shift_empty, .rx_char_busy, .rx_data_accept, .rx_fifo_read_allow,
    .direction_out);
`default_nettype wire
